// *** inc/internal_error_pkg.sv ***
// register map, field layout and reset values of the internal error report unit
package internal_error_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned FLAG_W = 19;
	localparam logic [11:0] OFFSET_REPORT_CONTROL = 12'h480;
	localparam logic [11:0] OFFSET_ERROR_FLAGS = 12'h484;
	localparam logic [11:0] OFFSET_REPORT_MASK = 12'h488;
	localparam logic [11:0] OFFSET_IRQ_MASK = 12'h48c;
	localparam int unsigned REPORT_ENABLE_BIT = 0;
	localparam logic [31:0] RESET_REPORT_CONTROL = 32'h0000_0001;
	localparam logic [18:0] RESET_FLAGS = 19'h0_0000;
	localparam logic [18:0] RESET_MASK = 19'h0_0000;
	// implemented flag bits; bit 3 is reserved
	localparam logic [18:0] FLAG_IMPLEMENTED = 19'h7_fff7;
	localparam int unsigned BIT_IN_POSTED_TO = 0;
	localparam int unsigned BIT_IN_NONPOSTED_TO = 1;
	localparam int unsigned BIT_IN_COMPLETION_TO = 2;
	localparam int unsigned BIT_OUT_POSTED_TO = 4;
	localparam int unsigned BIT_OUT_NONPOSTED_TO = 5;
	localparam int unsigned BIT_OUT_COMPLETION_TO = 6;
	localparam int unsigned BIT_IN_DATA_SINGLE = 7;
	localparam int unsigned BIT_IN_DATA_DOUBLE = 8;
	localparam int unsigned BIT_IN_CTRL_SINGLE = 9;
	localparam int unsigned BIT_IN_CTRL_DOUBLE = 10;
	localparam int unsigned BIT_OUT_DATA_SINGLE = 11;
	localparam int unsigned BIT_OUT_DATA_DOUBLE = 12;
	localparam int unsigned BIT_OUT_CTRL_SINGLE = 13;
	localparam int unsigned BIT_OUT_CTRL_DOUBLE = 14;
	localparam int unsigned BIT_PARITY = 15;
	localparam int unsigned BIT_UNRELIABLE_LINK = 16;
	localparam int unsigned BIT_REPLAY_SINGLE = 17;
	localparam int unsigned BIT_REPLAY_DOUBLE = 18;
endpackage

// *** design/sticky_flag.sv ***
// one write-one-to-clear sticky flag where a new event beats the clear
`timescale 1ns/1ps
`default_nettype none
module sticky_flag
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// event and clear
	input wire logic event_pulse,
	input wire logic clear_pulse,
	// state
	output logic flag
);
	typedef struct packed
	{
		logic flag;
	} state_t;
	state_t state;
	state_t next_state;

	always_comb
	begin
		next_state = state;
		if (event_pulse)
			next_state.flag = 1'b1;
		else if (clear_pulse)
			next_state.flag = 1'b0;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign flag = state.flag;
endmodule
`default_nettype wire

// *** design/rising_edge.sv ***
// turns a level into a one-cycle pulse on its rising edge
`timescale 1ns/1ps
`default_nettype none
module rising_edge
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// level in, pulse out
	input wire logic level,
	output logic pulse
);
	typedef struct packed
	{
		logic last;
	} state_t;
	state_t state;
	state_t next_state;

	always_comb
	begin
		next_state = state;
		next_state.last = level;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign pulse = level & ~state.last;
endmodule
`default_nettype wire

// *** design/internal_error_status_report.sv ***
// per-port internal error flags, masks and reporting to advanced error reporting
//
// Overview of operation
// - control bit 0 enables reporting, resets to one
// - flags 0..2: input buffer time-outs, sticky
// - flags 4..6: output buffer time-outs, write-one-clear
// - flags 7,8: input data RAM ECC errors
// - flags 9,10: input control RAM ECC errors
// - flags 11,12: output data RAM ECC errors
// - flags 13,14: output control RAM ECC errors
// - flag 15: datapath parity error
// - flag 16: unreliable link indication becomes set
// - flags 17,18: replay control RAM ECC errors
// - mask register blocks reporting, not flags
`timescale 1ns/1ps
`default_nettype none
module internal_error_status_report
	import internal_error_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [DATA_W-1:0] reg_rdata,
	// input buffer time-outs, one-cycle pulses
	input wire logic in_buf_posted_timeout,
	input wire logic in_buf_nonposted_timeout,
	input wire logic in_buf_completion_timeout,
	// output buffer time-outs
	input wire logic out_buf_posted_timeout,
	input wire logic out_buf_nonposted_timeout,
	input wire logic out_buf_completion_timeout,
	// ecc events
	input wire logic in_buf_data_single_ecc,
	input wire logic in_buf_data_double_ecc,
	input wire logic in_buf_ctrl_single_ecc,
	input wire logic in_buf_ctrl_double_ecc,
	input wire logic out_buf_data_single_ecc,
	input wire logic out_buf_data_double_ecc,
	input wire logic out_buf_ctrl_single_ecc,
	input wire logic out_buf_ctrl_double_ecc,
	input wire logic replay_ctrl_single_ecc,
	input wire logic replay_ctrl_double_ecc,
	// datapath parity pulse and link reliability level
	input wire logic datapath_parity_error,
	input wire logic unreliable_link_flag,
	// reporting
	output logic internal_error_report,
	output logic irq
);
	typedef struct packed
	{
		logic report_enable;
		logic [FLAG_W-1:0] report_mask;
		logic [FLAG_W-1:0] irq_mask;
		logic [DATA_W-1:0] rdata;
		logic report;
	} state_t;
	state_t state;
	state_t next_state;

	logic [FLAG_W-1:0] events;
	logic [FLAG_W-1:0] clears;
	logic [FLAG_W-1:0] flags;
	logic link_rise;

	//////////////////////////////////////////////////////////////////////////////
	// event collection

	rising_edge u_link_edge
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.level(unreliable_link_flag),
		.pulse(link_rise)
	);

	always_comb
	begin
		events = '0;
		events[BIT_IN_POSTED_TO] = in_buf_posted_timeout;
		events[BIT_IN_NONPOSTED_TO] = in_buf_nonposted_timeout;
		events[BIT_IN_COMPLETION_TO] = in_buf_completion_timeout;
		events[BIT_OUT_POSTED_TO] = out_buf_posted_timeout;
		events[BIT_OUT_NONPOSTED_TO] = out_buf_nonposted_timeout;
		events[BIT_OUT_COMPLETION_TO] = out_buf_completion_timeout;
		events[BIT_IN_DATA_SINGLE] = in_buf_data_single_ecc;
		events[BIT_IN_DATA_DOUBLE] = in_buf_data_double_ecc;
		events[BIT_IN_CTRL_SINGLE] = in_buf_ctrl_single_ecc;
		events[BIT_IN_CTRL_DOUBLE] = in_buf_ctrl_double_ecc;
		events[BIT_OUT_DATA_SINGLE] = out_buf_data_single_ecc;
		events[BIT_OUT_DATA_DOUBLE] = out_buf_data_double_ecc;
		events[BIT_OUT_CTRL_SINGLE] = out_buf_ctrl_single_ecc;
		events[BIT_OUT_CTRL_DOUBLE] = out_buf_ctrl_double_ecc;
		events[BIT_PARITY] = datapath_parity_error;
		events[BIT_UNRELIABLE_LINK] = link_rise;
		events[BIT_REPLAY_SINGLE] = replay_ctrl_single_ecc;
		events[BIT_REPLAY_DOUBLE] = replay_ctrl_double_ecc;
	end

	assign clears = (reg_write && reg_addr == OFFSET_ERROR_FLAGS) ?
		(reg_wdata[FLAG_W-1:0] & FLAG_IMPLEMENTED) : '0;

	//////////////////////////////////////////////////////////////////////////////
	// sticky flags

	sticky_flag u_in_posted
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_IN_POSTED_TO]),
		.clear_pulse(clears[BIT_IN_POSTED_TO]),
		.flag(flags[BIT_IN_POSTED_TO])
	);
	sticky_flag u_in_nonposted
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_IN_NONPOSTED_TO]),
		.clear_pulse(clears[BIT_IN_NONPOSTED_TO]),
		.flag(flags[BIT_IN_NONPOSTED_TO])
	);
	sticky_flag u_in_completion
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_IN_COMPLETION_TO]),
		.clear_pulse(clears[BIT_IN_COMPLETION_TO]),
		.flag(flags[BIT_IN_COMPLETION_TO])
	);
	sticky_flag u_out_posted
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_OUT_POSTED_TO]),
		.clear_pulse(clears[BIT_OUT_POSTED_TO]),
		.flag(flags[BIT_OUT_POSTED_TO])
	);
	sticky_flag u_out_nonposted
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_OUT_NONPOSTED_TO]),
		.clear_pulse(clears[BIT_OUT_NONPOSTED_TO]),
		.flag(flags[BIT_OUT_NONPOSTED_TO])
	);
	sticky_flag u_out_completion
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_OUT_COMPLETION_TO]),
		.clear_pulse(clears[BIT_OUT_COMPLETION_TO]),
		.flag(flags[BIT_OUT_COMPLETION_TO])
	);
	sticky_flag u_in_data_single
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_IN_DATA_SINGLE]),
		.clear_pulse(clears[BIT_IN_DATA_SINGLE]),
		.flag(flags[BIT_IN_DATA_SINGLE])
	);
	sticky_flag u_in_data_double
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_IN_DATA_DOUBLE]),
		.clear_pulse(clears[BIT_IN_DATA_DOUBLE]),
		.flag(flags[BIT_IN_DATA_DOUBLE])
	);
	sticky_flag u_in_ctrl_single
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_IN_CTRL_SINGLE]),
		.clear_pulse(clears[BIT_IN_CTRL_SINGLE]),
		.flag(flags[BIT_IN_CTRL_SINGLE])
	);
	sticky_flag u_in_ctrl_double
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_IN_CTRL_DOUBLE]),
		.clear_pulse(clears[BIT_IN_CTRL_DOUBLE]),
		.flag(flags[BIT_IN_CTRL_DOUBLE])
	);
	sticky_flag u_out_data_single
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_OUT_DATA_SINGLE]),
		.clear_pulse(clears[BIT_OUT_DATA_SINGLE]),
		.flag(flags[BIT_OUT_DATA_SINGLE])
	);
	sticky_flag u_out_data_double
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_OUT_DATA_DOUBLE]),
		.clear_pulse(clears[BIT_OUT_DATA_DOUBLE]),
		.flag(flags[BIT_OUT_DATA_DOUBLE])
	);
	sticky_flag u_out_ctrl_single
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_OUT_CTRL_SINGLE]),
		.clear_pulse(clears[BIT_OUT_CTRL_SINGLE]),
		.flag(flags[BIT_OUT_CTRL_SINGLE])
	);
	sticky_flag u_out_ctrl_double
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_OUT_CTRL_DOUBLE]),
		.clear_pulse(clears[BIT_OUT_CTRL_DOUBLE]),
		.flag(flags[BIT_OUT_CTRL_DOUBLE])
	);
	sticky_flag u_parity
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_PARITY]),
		.clear_pulse(clears[BIT_PARITY]),
		.flag(flags[BIT_PARITY])
	);
	sticky_flag u_link
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_UNRELIABLE_LINK]),
		.clear_pulse(clears[BIT_UNRELIABLE_LINK]),
		.flag(flags[BIT_UNRELIABLE_LINK])
	);
	sticky_flag u_replay_single
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_REPLAY_SINGLE]),
		.clear_pulse(clears[BIT_REPLAY_SINGLE]),
		.flag(flags[BIT_REPLAY_SINGLE])
	);
	sticky_flag u_replay_double
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.event_pulse(events[BIT_REPLAY_DOUBLE]),
		.clear_pulse(clears[BIT_REPLAY_DOUBLE]),
		.flag(flags[BIT_REPLAY_DOUBLE])
	);
	// bit 3 is reserved and always reads zero
	assign flags[3] = 1'b0;

	//////////////////////////////////////////////////////////////////////////////
	// registers and reporting

	always_comb
	begin
		next_state = state;
		if (reg_write)
		begin
			unique case (reg_addr)
				OFFSET_REPORT_CONTROL:
					next_state.report_enable = reg_wdata[REPORT_ENABLE_BIT];
				OFFSET_REPORT_MASK:
					next_state.report_mask = reg_wdata[FLAG_W-1:0] & FLAG_IMPLEMENTED;
				OFFSET_IRQ_MASK:
					next_state.irq_mask = reg_wdata[FLAG_W-1:0] & FLAG_IMPLEMENTED;
				default:
					next_state.rdata = state.rdata;
			endcase
		end
		next_state.rdata = '0;
		if (reg_read)
		begin
			unique case (reg_addr)
				OFFSET_REPORT_CONTROL:
					next_state.rdata = {{(DATA_W-1){1'b0}}, state.report_enable};
				OFFSET_ERROR_FLAGS:
					next_state.rdata = {{(DATA_W-FLAG_W){1'b0}}, flags};
				OFFSET_REPORT_MASK:
					next_state.rdata = {{(DATA_W-FLAG_W){1'b0}}, state.report_mask};
				OFFSET_IRQ_MASK:
					next_state.rdata = {{(DATA_W-FLAG_W){1'b0}}, state.irq_mask};
				default:
					next_state.rdata = '0;
			endcase
		end
		// masked flags stay visible but do not report
		next_state.report = state.report_enable && |(flags & ~state.report_mask);
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state.report_enable <= RESET_REPORT_CONTROL[REPORT_ENABLE_BIT];
			state.report_mask <= RESET_MASK;
			state.irq_mask <= RESET_MASK;
			state.rdata <= '0;
			state.report <= 1'b0;
		end
		else
			state <= next_state;
	end

	assign reg_rdata = state.rdata;
	assign internal_error_report = state.report;
	assign irq = |(flags & ~state.irq_mask);
endmodule
`default_nettype wire

// *** dv/internal_error_status_report_sva.sv ***
// port checker for the internal error report unit
`timescale 1ns/1ps
`default_nettype none
module internal_error_status_report_sva
	import internal_error_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [DATA_W-1:0] reg_rdata,
	// events and reporting
	input wire logic in_buf_posted_timeout,
	input wire logic datapath_parity_error,
	input wire logic unreliable_link_flag,
	input wire logic internal_error_report,
	input wire logic irq
);
	logic en;
	logic [18:0] rmask;
	logic all_masked;
	logic rd_sts;
	logic clr0;
	assign all_masked = &(rmask | ~FLAG_IMPLEMENTED);
	assign rd_sts = reg_read && reg_addr == OFFSET_ERROR_FLAGS;
	assign clr0 = reg_write && reg_addr == OFFSET_ERROR_FLAGS && reg_wdata[0];
	// shadow of the enable and report mask
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			en <= 1'b1;
			rmask <= RESET_MASK;
		end
		else if (reg_write && reg_addr == OFFSET_REPORT_CONTROL)
			en <= reg_wdata[0];
		else if (reg_write && reg_addr == OFFSET_REPORT_MASK)
			rmask <= reg_wdata[18:0];
	end
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	ctl_resv_a: assert property (reg_read && reg_addr == OFFSET_REPORT_CONTROL |=> reg_rdata[31:1] == '0)
		else $error("control reserved bits not zero");
	sts_resv_a: assert property (rd_sts |=> reg_rdata[31:19] == '0 && !reg_rdata[3])
		else $error("flag reserved bits not zero");
	posted_set_a: assert property (in_buf_posted_timeout ##1 rd_sts |=> reg_rdata[0])
		else $error("posted time-out flag not set");
	parity_set_a: assert property (datapath_parity_error ##1 rd_sts |=> reg_rdata[15])
		else $error("parity flag not set");
	link_edge_a: assert property ($rose(unreliable_link_flag) ##1 rd_sts |=> reg_rdata[16])
		else $error("unreliable link flag not set");
	set_wins_a: assert property (in_buf_posted_timeout && clr0 ##1 rd_sts |=> reg_rdata[0])
		else $error("clear beat a new event");
	report_off_a: assert property (!$past(en) |-> !internal_error_report)
		else $error("report while disabled");
	all_masked_a: assert property ($past(all_masked) |-> !internal_error_report)
		else $error("report while all masked");
	report_on_a: assert property (in_buf_posted_timeout && en && !rmask[0] && !reg_write |-> ##2 internal_error_report)
		else $error("report missing");
	set_wins_c: cover property (in_buf_posted_timeout && clr0);
	report_c: cover property (internal_error_report);
	irq_c: cover property (irq);
endmodule
bind internal_error_status_report internal_error_status_report_sva sva (.*);
`default_nettype wire

// *** dv/internal_error_status_report_bench.sv ***
// random and corner tests of the internal error report unit
`timescale 1ns/1ps
`default_nettype none
module internal_error_status_report_bench
	import internal_error_pkg::*;
;
	logic clk_sys, arst_n, reg_write, reg_read, en;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, seed, w, rm;
	logic [18:0] e, s, exp;
	logic internal_error_report, irq;
	int failures, checks;
	internal_error_status_report dut (.*, .in_buf_posted_timeout(e[0]), .in_buf_nonposted_timeout(e[1]),
		.in_buf_completion_timeout(e[2]), .out_buf_posted_timeout(e[4]), .out_buf_nonposted_timeout(e[5]),
		.out_buf_completion_timeout(e[6]), .in_buf_data_single_ecc(e[7]), .in_buf_data_double_ecc(e[8]),
		.in_buf_ctrl_single_ecc(e[9]), .in_buf_ctrl_double_ecc(e[10]), .out_buf_data_single_ecc(e[11]),
		.out_buf_data_double_ecc(e[12]), .out_buf_ctrl_single_ecc(e[13]), .out_buf_ctrl_double_ecc(e[14]),
		.datapath_parity_error(e[15]), .unreliable_link_flag(e[16]), .replay_ctrl_single_ecc(e[17]),
		.replay_ctrl_double_ecc(e[18]));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want)
			$display("MISMATCH %0t seen %h expected %h", $time, seen, want);
		if (seen !== want)
			failures++;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] want);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1 check(reg_rdata, want);
	endtask
	task automatic conclude();
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial
	begin
		#200000;
		failures++;
		conclude();
	end
	initial
	begin
		{arst_n, reg_write, reg_read, reg_addr, reg_wdata, e, exp} = '0;
		seed = 32'h8d28fca0;
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		rd(OFFSET_REPORT_CONTROL, 32'h1);
		rd(OFFSET_ERROR_FLAGS, 32'h0);
		rd(OFFSET_REPORT_MASK, 32'h0);
		rd(OFFSET_IRQ_MASK, 32'h0);
		rd(12'h490, 32'h0);
		wr(OFFSET_REPORT_CONTROL, 32'hffff_fffe);
		rd(OFFSET_REPORT_CONTROL, 32'h0);
		for (int m = 0; m < 3; m++)
		begin
			rm = (m == 1) ? rnd() : 32'h0;
			en = (m != 2);
			wr(OFFSET_REPORT_CONTROL, {31'h0, en});
			wr(OFFSET_REPORT_MASK, rm);
			wr(OFFSET_IRQ_MASK, rm);
			rd(OFFSET_REPORT_MASK, {13'h0, rm[18:0] & FLAG_IMPLEMENTED});
			for (int i = 0; i < 40; i++)
			begin
				// each mode: all events race a full clear, then all events alone; odd passes never write
				s = (i < 2) ? FLAG_IMPLEMENTED : FLAG_IMPLEMENTED & 19'(rnd() & rnd() & rnd());
				w = (i == 0) ? 32'hffff_ffff : ((i % 2 == 0) ? rnd() & rnd() : 32'h0);
				@(posedge clk_sys);
				e <= s;
				reg_addr <= OFFSET_ERROR_FLAGS;
				reg_wdata <= w;
				reg_write <= (i % 2 == 0);
				@(posedge clk_sys);
				e <= '0;
				reg_write <= 1'b0;
				reg_read <= 1'b1;
				exp = (exp & ~w[18:0] & FLAG_IMPLEMENTED) | s;
				@(posedge clk_sys);
				reg_read <= 1'b0;
				#1 check(reg_rdata, {13'h0, exp});
				check({31'h0, irq}, {31'h0, |(exp & ~rm[18:0])});
				check({31'h0, internal_error_report}, {31'h0, en && |(exp & ~rm[18:0])});
			end
		end
		// mid-run reset puts every register back to its reset value
		arst_n <= 1'b0;
		#1 check({31'h0, internal_error_report}, 32'h0);
		check({31'h0, irq}, 32'h0);
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		rd(OFFSET_REPORT_CONTROL, 32'h1);
		rd(OFFSET_ERROR_FLAGS, 32'h0);
		rd(OFFSET_REPORT_MASK, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
